// >>> rtl/dcr_bank.sv
// Serial-bus register bank of the deserializer
//
// Contract
// - Reg 0 bit 7 picks spread low-frequency mode; resets to 0.
// - Reg 0 bit 6 picks LSB or MSB on the fourth output pair.
// - Reg 0 bits 3:2: 00 filter off, 01 on, others reserved.
// - Reg 0 bit 1 sleeps the device; register contents kept.
// - Reg 0 bit 0: config from pins when 0, registers when 1.
// - Reg 1 bit 7: bus address from strap when 0, register when 1.
// - Reg 1 bits 6:0 bus address, valid 71,72,73,76; resets 1110000.
// - Reg 2 bit 7 output enable, bit 6 output sleep state; reset 0.
// - Reg 2 bit 3 picks output swing 250 mV or 400 mV.
// - Reg 2 bits 2:0 oscillator: off, reserved, 25 down to 6.3 MHz.
// - Normal mode spread codes: 001-100 CLK/2168, 101-111 CLK/1300.
// - Low-frequency spread codes: 001-100 CLK/625, 101-111 CLK/385.
// - Device acknowledges its bus address by pulling data low.
`timescale 1ns/1ps
`default_nettype none
module dcr_bank (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [6:0] busAddressStrap,
  input wire logic lowFreqModePin,
  input wire logic bitMapSelectPin,
  input wire logic outputEnablePin,
  input wire logic outputSleepStatePin,
  input wire logic outputSwingSelectPin,
  output logic lowFreqMode,
  output logic bitMapSelect,
  output logic filterEnable,
  output logic sleepMode,
  output logic outputEnable,
  output logic outputSleepState,
  output logic outputSwingSelect,
  output logic [2:0] oscillatorSelect,
  output logic equalizerEnable,
  output logic [2:0] equalizerGain,
  output logic [2:0] spreadProfileSelect,
  output logic [11:0] spreadModDivide
);
  ////////////////////////////////////////////////////////////////////////////
  dcr_sync_if #(.WIDTH(dcr_pkg::SYNC_WIDTH)) lines ();
  logic [dcr_pkg::SYNC_WIDTH-1:0] lineLvl;
  logic [dcr_pkg::SYNC_WIDTH-1:0] lineLvlD_ff;
  logic sclNow, sdaNow, sclRise, sclFall, startCond, stopCond;

  dcr_sync #(.WIDTH(dcr_pkg::SYNC_WIDTH)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pinIn({outputSwingSelectPin, outputSleepStatePin, outputEnablePin,
            bitMapSelectPin, lowFreqModePin, sdaIn, scl}),
    .resetLevel({dcr_pkg::SYNC_WIDTH{1'b1}}),
    .syncOut(lines.det)
  );

  assign lineLvl = lines.level;
  assign sclNow = lineLvl[0];
  assign sdaNow = lineLvl[1];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lineLvlD_ff <= {dcr_pkg::SYNC_WIDTH{1'b1}};
    end else begin
      lineLvlD_ff <= lineLvl;
    end
  end

  assign sclRise = sclNow && !lineLvlD_ff[0];
  assign sclFall = !sclNow && lineLvlD_ff[0];
  assign startCond = sclNow && lineLvlD_ff[0] && !sdaNow && lineLvlD_ff[1];
  assign stopCond = sclNow && lineLvlD_ff[0] && sdaNow && !lineLvlD_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // Strap caught after reset release, never under the async reset
  logic [6:0] strapAddr_ff;
  logic strapTaken_ff;
  logic [7:0] regs_ff [dcr_pkg::REG_COUNT];
  logic [6:0] activeAddr;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strapAddr_ff <= 7'h00;
      strapTaken_ff <= 1'b0;
    end else if (!strapTaken_ff) begin
      strapAddr_ff <= busAddressStrap;
      strapTaken_ff <= 1'b1;
    end
  end

  assign activeAddr = regs_ff[1][dcr_pkg::BIT_ADDR_SRC] ? regs_ff[1][6:0]
                                                         : strapAddr_ff;

  ////////////////////////////////////////////////////////////////////////////
  dcr_pkg::dcr_state_e state_ff;
  logic [3:0] bitCnt_ff;
  logic ackPhase_ff;
  logic isRead_ff;
  logic masterAck_ff;
  logic [7:0] shift_ff;
  logic [7:0] ptr_ff;
  logic wrEn;
  logic [7:0] rdData;
  logic byteEnd;

  assign byteEnd = sclFall && bitCnt_ff == dcr_pkg::BITS_PER_BYTE
                   && !ackPhase_ff;
  assign wrEn = byteEnd && state_ff == dcr_pkg::ST_WRITE
                && ptr_ff < 8'(dcr_pkg::REG_COUNT);
  assign rdData = (ptr_ff < 8'(dcr_pkg::REG_COUNT)) ? regs_ff[ptr_ff[1:0]]
                                                    : 8'h00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= dcr_pkg::ST_IDLE;
      bitCnt_ff <= 4'h0;
      ackPhase_ff <= 1'b0;
      isRead_ff <= 1'b0;
      masterAck_ff <= 1'b0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
    end else if (stopCond) begin
      state_ff <= dcr_pkg::ST_IDLE;
      sdaOe <= 1'b0;
    end else if (startCond) begin
      state_ff <= dcr_pkg::ST_ADDR;
      bitCnt_ff <= 4'h0;
      ackPhase_ff <= 1'b0;
      sdaOe <= 1'b0;
    end else if (state_ff != dcr_pkg::ST_IDLE) begin
      if (sclRise) begin
        if (bitCnt_ff < dcr_pkg::BITS_PER_BYTE) begin
          shift_ff <= {shift_ff[6:0], sdaNow};
          bitCnt_ff <= bitCnt_ff + 4'h1;
        end else if (ackPhase_ff) begin
          masterAck_ff <= !sdaNow;
        end
      end else if (byteEnd) begin
        ackPhase_ff <= 1'b1;
        sdaOut <= 1'b0;
        case (state_ff)
          dcr_pkg::ST_ADDR: begin
            if (shift_ff[7:1] == activeAddr) begin
              sdaOe <= 1'b1;
              isRead_ff <= shift_ff[0];
            end else begin
              state_ff <= dcr_pkg::ST_IDLE;
              sdaOe <= 1'b0;
            end
          end
          dcr_pkg::ST_PTR: begin
            ptr_ff <= shift_ff;
            sdaOe <= 1'b1;
          end
          dcr_pkg::ST_WRITE: begin
            ptr_ff <= ptr_ff + 8'h01;
            sdaOe <= 1'b1;
          end
          default: begin
            sdaOe <= 1'b0;
          end
        endcase
      end else if (sclFall && ackPhase_ff) begin
        ackPhase_ff <= 1'b0;
        bitCnt_ff <= 4'h0;
        sdaOe <= 1'b0;
        case (state_ff)
          dcr_pkg::ST_ADDR: begin
            if (isRead_ff) begin
              state_ff <= dcr_pkg::ST_READ;
              shift_ff <= rdData;
              ptr_ff <= ptr_ff + 8'h01;
              sdaOe <= !rdData[7];
            end else begin
              state_ff <= dcr_pkg::ST_PTR;
            end
          end
          dcr_pkg::ST_PTR: begin
            state_ff <= dcr_pkg::ST_WRITE;
          end
          dcr_pkg::ST_READ: begin
            if (masterAck_ff) begin
              shift_ff <= rdData;
              ptr_ff <= ptr_ff + 8'h01;
              sdaOe <= !rdData[7];
            end else begin
              state_ff <= dcr_pkg::ST_IDLE;
            end
          end
          default: begin
            state_ff <= state_ff;
          end
        endcase
      end else if (sclFall && state_ff == dcr_pkg::ST_READ
                   && bitCnt_ff < dcr_pkg::BITS_PER_BYTE) begin
        // Open drain: only zeros are driven
        sdaOe <= !shift_ff[7];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Whole byte stored, reserved bits included, so they read back
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regs_ff[0] <= dcr_pkg::RST_CONFIG_ONE;
      regs_ff[1] <= dcr_pkg::RST_BUS_ADDR;
      regs_ff[2] <= dcr_pkg::RST_FEATURES_ONE;
      regs_ff[3] <= dcr_pkg::RST_FEATURES_TWO;
    end else if (wrEn) begin
      regs_ff[ptr_ff[1:0]] <= shift_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic cfgFromRegs;
  logic lowFreqSel;
  logic [2:0] spreadCode;
  logic [11:0] nxt_spreadModDivide;

  assign cfgFromRegs = regs_ff[0][dcr_pkg::BIT_CFG_SRC];
  assign lowFreqSel = cfgFromRegs ? regs_ff[0][dcr_pkg::BIT_LOW_FREQ]
                                  : lineLvl[2];
  assign spreadCode = regs_ff[3][2:0];

  always_comb begin
    if (spreadCode == dcr_pkg::SPREAD_OFF) begin
      nxt_spreadModDivide = 12'h000;
    end else if (lowFreqSel) begin
      nxt_spreadModDivide = (spreadCode >= dcr_pkg::SPREAD_FAST)
                          ? dcr_pkg::DIV_LF_FAST : dcr_pkg::DIV_LF_SLOW;
    end else begin
      nxt_spreadModDivide = (spreadCode >= dcr_pkg::SPREAD_FAST)
                          ? dcr_pkg::DIV_HF_FAST : dcr_pkg::DIV_HF_SLOW;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lowFreqMode <= 1'b0;
      bitMapSelect <= 1'b0;
      outputEnable <= 1'b0;
      outputSleepState <= 1'b0;
      outputSwingSelect <= 1'b0;
    end else if (cfgFromRegs) begin
      lowFreqMode <= regs_ff[0][dcr_pkg::BIT_LOW_FREQ];
      bitMapSelect <= regs_ff[0][dcr_pkg::BIT_MAP_SEL];
      outputEnable <= regs_ff[2][dcr_pkg::BIT_OUT_EN];
      outputSleepState <= regs_ff[2][dcr_pkg::BIT_OUT_SLEEP];
      outputSwingSelect <= regs_ff[2][dcr_pkg::BIT_SWING];
    end else begin
      lowFreqMode <= lineLvl[2];
      bitMapSelect <= lineLvl[3];
      outputEnable <= lineLvl[4];
      outputSleepState <= lineLvl[5];
      outputSwingSelect <= lineLvl[6];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      filterEnable <= 1'b0;
      sleepMode <= 1'b0;
      oscillatorSelect <= 3'h0;
      equalizerEnable <= 1'b0;
      equalizerGain <= 3'h0;
      spreadProfileSelect <= 3'h0;
      spreadModDivide <= 12'h000;
    end else begin
      filterEnable <= regs_ff[0][dcr_pkg::BIT_FILTER_HI:dcr_pkg::BIT_FILTER_LO]
                      == dcr_pkg::FILTER_ON;
      sleepMode <= regs_ff[0][dcr_pkg::BIT_SLEEP];
      // Reserved oscillator code treated as off
      oscillatorSelect <= (regs_ff[2][2:0] == dcr_pkg::OSC_RESERVED)
                          ? 3'h0 : regs_ff[2][2:0];
      equalizerEnable <= regs_ff[3][dcr_pkg::BIT_EQ_EN];
      equalizerGain <= regs_ff[3][dcr_pkg::BIT_EQUALIZER_GAIN_HI:
                                  dcr_pkg::BIT_EQUALIZER_GAIN_LO];
      spreadProfileSelect <= spreadCode;
      spreadModDivide <= nxt_spreadModDivide;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  addr_ack_a: assert property (byteEnd && state_ff == dcr_pkg::ST_ADDR
    && shift_ff[7:1] == activeAddr |=> sdaOe && !sdaOut ##1 $stable(sdaOe))
    else $error("address match not acknowledged");
  strap_nack_a: assert property (byteEnd && state_ff == dcr_pkg::ST_ADDR
    && !regs_ff[1][7] && shift_ff[7:1] != strapAddr_ff |=> !sdaOe
    && state_ff == dcr_pkg::ST_IDLE)
    else $error("foreign address acknowledged");
  addr_reset_a: assert property ($rose(strapTaken_ff)
    |-> regs_ff[1] == dcr_pkg::RST_BUS_ADDR)
    else $error("address register reset value wrong");
  filter_code_a: assert property (##1 filterEnable
    |-> $past(regs_ff[0][3:2]) == 2'h1)
    else $error("filter enabled by reserved code");
  sleep_keep_a: assert property ($rose(regs_ff[0][1]) |=> sleepMode
    && $stable(regs_ff[2]) && $stable(regs_ff[3]))
    else $error("sleep not entered or settings lost");
  cfg_source_a: assert property (cfgFromRegs && $stable(cfgFromRegs)
    |=> lowFreqMode == $past(regs_ff[0][7])
    && bitMapSelect == $past(regs_ff[0][6])
    && outputEnable == $past(regs_ff[2][7]))
    else $error("register config not applied");
  swing_sel_a: assert property (cfgFromRegs ##1 cfgFromRegs
    |-> outputSwingSelect == $past(regs_ff[2][3]))
    else $error("swing select mismatch");
  osc_res_a: assert property (regs_ff[2][2:0] == 3'h1
    |=> oscillatorSelect == 3'h0)
    else $error("reserved oscillator code passed on");
  spread_hf_a: assert property (!lowFreqSel && spreadCode >= 3'h1
    && spreadCode <= 3'h4 |=> spreadModDivide == 12'd2168)
    else $error("normal mode divider wrong");
  spread_lf_a: assert property (lowFreqSel && spreadCode >= 3'h5
    |=> spreadModDivide == 12'd385)
    else $error("low frequency divider wrong");

  write_cv: cover property (wrEn);
  read_cv: cover property (state_ff == dcr_pkg::ST_READ && byteEnd);
  sleep_cv: cover property ($rose(sleepMode));
  nack_cv: cover property (byteEnd && state_ff == dcr_pkg::ST_ADDR
    && shift_ff[7:1] != activeAddr);
endmodule // dcr_bank
`default_nettype wire

// >>> rtl/dcr_pkg.sv
// Constants and types of the deserializer control register bank
package dcr_pkg;
  localparam int REG_COUNT = 4;
  localparam logic [7:0] OFS_CONFIG_ONE = 8'h00;
  localparam logic [7:0] OFS_BUS_ADDR = 8'h01;
  localparam logic [7:0] OFS_FEATURES_ONE = 8'h02;
  localparam logic [7:0] OFS_FEATURES_TWO = 8'h03;
  localparam logic [7:0] RST_CONFIG_ONE = 8'h00;
  localparam logic [7:0] RST_BUS_ADDR = 8'h70;
  localparam logic [7:0] RST_FEATURES_ONE = 8'h00;
  localparam logic [7:0] RST_FEATURES_TWO = 8'h00;
  // Config one fields
  localparam int BIT_LOW_FREQ = 7;
  localparam int BIT_MAP_SEL = 6;
  localparam int BIT_FILTER_HI = 3;
  localparam int BIT_FILTER_LO = 2;
  localparam int BIT_SLEEP = 1;
  localparam int BIT_CFG_SRC = 0;
  localparam logic [1:0] FILTER_ON = 2'h1;
  // Bus address fields
  localparam int BIT_ADDR_SRC = 7;
  // Features one fields
  localparam int BIT_OUT_EN = 7;
  localparam int BIT_OUT_SLEEP = 6;
  localparam int BIT_SWING = 3;
  localparam logic [2:0] OSC_RESERVED = 3'h1;
  // Features two fields
  localparam int BIT_EQUALIZER_GAIN_HI = 7;
  localparam int BIT_EQUALIZER_GAIN_LO = 5;
  localparam int BIT_EQ_EN = 4;
  localparam logic [2:0] SPREAD_OFF = 3'h0;
  localparam logic [2:0] SPREAD_FAST = 3'h5;
  // Modulation divisors of the spread clock generator
  localparam logic [11:0] DIV_HF_SLOW = 12'd2168;
  localparam logic [11:0] DIV_HF_FAST = 12'd1300;
  localparam logic [11:0] DIV_LF_SLOW = 12'd625;
  localparam logic [11:0] DIV_LF_FAST = 12'd385;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int SYNC_WIDTH = 7;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WRITE, ST_READ
  } dcr_state_e;
endpackage

// >>> rtl/dcr_sync_if.sv
// Filtered pin levels passed from the synchroniser to the bank
`timescale 1ns/1ps
`default_nettype none
interface dcr_sync_if #(parameter int WIDTH = 7);
  logic [WIDTH-1:0] level;
  modport det (output level);
  modport eng (input level);
endinterface
`default_nettype wire

// >>> rtl/dcr_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dcr_sync #(
  parameter int WIDTH = 7
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pinIn,
  input wire logic [WIDTH-1:0] resetLevel,
  dcr_sync_if.det syncOut
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] level_ff;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          stage1_ff[i] <= 1'b1;
          stage2_ff[i] <= 1'b1;
          stage3_ff[i] <= 1'b1;
          level_ff[i] <= 1'b1;
        end else begin
          stage1_ff[i] <= pinIn[i];
          stage2_ff[i] <= stage1_ff[i];
          stage3_ff[i] <= stage2_ff[i];
          // Change taken only once the last two stages agree
          if (stage2_ff[i] == stage3_ff[i]) begin
            level_ff[i] <= stage3_ff[i];
          end
        end
      end
    end
  endgenerate

  // Reset level unused at flop level; constants only under reset
  assign syncOut.level = level_ff;
endmodule // dcr_sync
`default_nettype wire

// >>> tb/dcr_bus_master.sv
// Serial control bus master model facing the register bank
`timescale 1ns/1ps
`default_nettype none
module dcr_bus_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // Ten clocks a half period, above the filter's two-clock minimum
  task automatic half();
    repeat (10) @(posedge clk);
    #2;
  endtask
  // Data only moves while the clock is low, a half period after its fall
  task automatic slot(input logic low, output logic s);
    half();
    sdaLow = low;
    half();
    scl = 1'b1;
    half();
    s = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    half();
    sdaLow = 1'b0;
    half();
    scl = 1'b1;
    half();
    sdaLow = 1'b1;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    half();
    sdaLow = 1'b1;
    half();
    scl = 1'b1;
    half();
    sdaLow = 1'b0;
    half();
  endtask
  // Most significant bit first, ack is a low level in the ninth slot
  task automatic send(input logic [7:0] b, output logic ak);
    logic s;
    for (int i = 7; i >= 0; i--) slot(~b[i], s);
    slot(1'b0, s);
    ak = ~s;
  endtask
  task automatic recv(input logic last, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b0, s);
      v[i] = s;
    end
    slot(~last, s);
  endtask
endmodule // dcr_bus_master
`default_nettype wire

// >>> tb/deser_control_registers_tb_top.sv
// Self-checking bench of the deserializer control register bank
`timescale 1ns/1ps
`default_nettype none
module deser_control_registers_tb_top;
  localparam logic [6:0] ADDR_A = 7'h71;
  localparam logic [6:0] ADDR_B = 7'h76;
  logic clk, nrst, scl, sdaLow, sdaOut, sdaOe, ak;
  logic [6:0] strap;
  logic [4:0] pins;
  logic lowFreqMode, bitMapSelect, filterEnable, sleepMode, outputEnable;
  logic outputSleepState, outputSwingSelect, equalizerEnable;
  logic [2:0] oscillatorSelect, equalizerGain, spreadProfileSelect;
  logic [11:0] spreadModDivide;
  int nMismatch = 0;
  int cmpCount = 0;
  wire sda;
  // Pulled-up wire: low only while some party pulls it
  assign sda = !(sdaLow || (sdaOe && !sdaOut));
  dcr_bus_master m (.clk, .sda, .scl, .sdaLow);
  dcr_bank dut (.clk, .nrst, .scl, .sdaIn(sda), .sdaOut, .sdaOe,
    .busAddressStrap(strap), .lowFreqModePin(pins[4]),
    .bitMapSelectPin(pins[3]), .outputEnablePin(pins[2]),
    .outputSleepStatePin(pins[1]), .outputSwingSelectPin(pins[0]),
    .lowFreqMode, .bitMapSelect, .filterEnable, .sleepMode, .outputEnable,
    .outputSleepState, .outputSwingSelect, .oscillatorSelect,
    .equalizerEnable, .equalizerGain, .spreadProfileSelect,
    .spreadModDivide);
  always #25 clk = ~clk;
  task automatic chk(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
      input logic [7:0] d [$]);
    logic x;
    m.start();
    m.send({a, 1'b0}, ak);
    if (ak) begin
      m.send(p, x);
      foreach (d[i]) begin
        m.send(d[i], x);
        chk("data ack", 16'(x), 16'h1);
      end
    end
    m.stop();
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] p,
      input logic [7:0] e);
    logic x;
    logic [7:0] v;
    m.start();
    m.send({a, 1'b0}, x);
    m.send(p, x);
    m.start();
    m.send({a, 1'b1}, x);
    m.recv(1'b1, v);
    m.stop();
    chk("register read", 16'(v), 16'(e));
  endtask
  task automatic t_reset();
    rchk(ADDR_A, 8'h00, 8'h00);
    rchk(ADDR_A, 8'h01, 8'h70);
    rchk(ADDR_A, 8'h02, 8'h00);
    rchk(ADDR_A, 8'h03, 8'h00);
    chk("outputs", 16'({sleepMode, filterEnable, spreadModDivide}),
      16'h0);
    $display("test reset done");
  endtask
  task automatic t_badaddr();
    wr(7'h72, 8'h00, '{8'h01});
    chk("foreign address ack", 16'(ak), 16'h0);
    rchk(ADDR_A, 8'h00, 8'h00);
    $display("test foreign address done");
  endtask
  task automatic t_config();
    wr(ADDR_A, 8'h00, '{8'hf7});
    chk("low freq", 16'(lowFreqMode), 16'h1);
    chk("bit map", 16'(bitMapSelect), 16'h1);
    chk("sleep", 16'(sleepMode), 16'h1);
    rchk(ADDR_A, 8'h00, 8'hf7);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_A, 8'h00, '{{4'h0, 2'(c), 2'h1}});
      chk("filter", 16'(filterEnable), 16'(c == 1));
      chk("awake", 16'({sleepMode, lowFreqMode, bitMapSelect}), 16'h0);
      rchk(ADDR_A, 8'h00, {4'h0, 2'(c), 2'h1});
    end
    $display("test config done");
  endtask
  task automatic t_features();
    logic [2:0] k;
    logic [7:0] d;
    for (int c = 0; c < 8; c++) begin
      k = 3'(c);
      d = {k[0], k[1], 2'h3, k[2], k};
      wr(ADDR_A, 8'h02, '{d});
      chk("out enable", 16'(outputEnable), 16'(k[0]));
      chk("out sleep", 16'(outputSleepState), 16'(k[1]));
      chk("swing", 16'(outputSwingSelect), 16'(k[2]));
      chk("osc", 16'(oscillatorSelect), 16'((k == 3'h1) ? 3'h0 : k));
      rchk(ADDR_A, 8'h02, d);
    end
    $display("test features done");
  endtask
  task automatic t_spread();
    logic [2:0] k;
    logic [11:0] e;
    for (int i = 0; i < 16; i++) begin
      k = 3'(i);
      if (k == 3'h0) e = 12'h0;
      else if (i > 7) e = (k < 3'h5) ? 12'h271 : 12'h181;
      else e = (k < 3'h5) ? 12'h878 : 12'h514;
      wr(ADDR_A, 8'h00, '{{i > 7, 7'h01}, 8'h70, 8'h00, {k, 2'h3, k}});
      chk("low freq", 16'(lowFreqMode), 16'(i > 7));
      chk("profile", 16'(spreadProfileSelect), 16'(k));
      chk("eq", 16'({equalizerGain, equalizerEnable}), 16'({k, 1'b1}));
      chk("divider", 16'(spreadModDivide), 16'(e));
    end
    $display("test spread done");
  endtask
  task automatic t_pins();
    wr(ADDR_A, 8'h00, '{8'h00});
    for (int i = 0; i < 2; i++) begin
      pins = i ? 5'h0a : 5'h1f;
      repeat (10) @(posedge clk);
      #2;
      chk("pin config", 16'({lowFreqMode, bitMapSelect, outputEnable,
        outputSleepState, outputSwingSelect}), 16'(pins));
    end
    pins = 5'h00;
    $display("test pins done");
  endtask
  task automatic t_addr();
    wr(ADDR_A, 8'h01, '{8'hf6});
    wr(ADDR_A, 8'h00, '{8'h01});
    chk("strap ack", 16'(ak), 16'h0);
    rchk(ADDR_B, 8'h01, 8'hf6);
    strap = 7'h73;
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    nrst = 1'b1;
    repeat (10) @(posedge clk);
    rchk(7'h73, 8'h01, 8'h70);
    rchk(7'h73, 8'h02, 8'h00);
    $display("test address done");
  endtask
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    strap = ADDR_A;
    pins = 5'h00;
    repeat (2) @(posedge clk);
    #2;
    nrst = 1'b1;
    repeat (10) @(posedge clk);
    t_reset();
    t_badaddr();
    t_config();
    t_features();
    t_spread();
    t_pins();
    t_addr();
    final_report();
  end
  // About 66 thousand clocks expected; cut off well past that
  initial begin
    #4500us;
    nMismatch++;
    final_report();
  end
endmodule // deser_control_registers_tb_top
`default_nettype wire
